// ==== pacl_pkg.sv ====
/*
 package for the port access and aggregation select block:
 register offsets, field positions, reset values and state codes.
 assumes the apb slave in the top module and the mask memory module.
*/
package pacl_pkg;
   localparam int          NPORTS          = 12;
   localparam int          NQUEUES         = 8;
   localparam int          NAGGR           = 16;
   localparam int          AC_W            = 4;
   localparam logic [47:0] AUTH_DMAC       = 48'h0180C2000003;
   localparam int          RSV_IDX_AUTH    = 3;

   localparam logic [11:0] OFF_PORT_CFG    = 12'h080;
   localparam logic [11:0] OFF_REDIR_ENA   = 12'h004;
   localparam logic [11:0] OFF_CPUQ        = 12'h008;
   localparam logic [11:0] OFF_AGGR_CFG    = 12'h00C;
   localparam logic [11:0] OFF_STATUS      = 12'h010;
   localparam logic [11:0] OFF_FWD_CNT     = 12'h014;
   localparam logic [11:0] OFF_CPU_CNT     = 12'h018;
   localparam logic [11:0] OFF_DROP_CNT    = 12'h01C;
   localparam logic [11:0] OFF_AGGR_MASK   = 12'h040;

   localparam int          PC_PORT_LEARNING_ENABLE    = 0;
   localparam int          PC_LEARN_CPU    = 1;
   localparam int          PC_LEARN_DROP   = 2;
   localparam int          PC_LEARN_AUTO   = 3;
   localparam int          PC_PORT_SEL_LO  = 8;

   localparam int          AG_IP6_FLOW     = 0;
   localparam int          AG_IP4_SIPDIP   = 1;
   localparam int          AG_IP4_L4       = 2;
   localparam int          AG_IP6_L4       = 3;
   localparam int          AG_DMAC         = 4;
   localparam int          AG_SMAC         = 5;
   localparam int          AG_RND          = 6;

   localparam logic [31:0] PORT_CFG_RST    = 32'h00000000;
   localparam logic [31:0] AGGR_CFG_RST    = 32'h0000003F;
   localparam logic [11:0] MASK_RST        = 12'hFFF;
   localparam logic [15:0] LFSR_SEED       = 16'hACE1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOOK = 2'b01,
      ST_DONE = 2'b10
   } state_type;

   typedef enum logic [1:0] {
      ACT_FWD   = 2'b00,
      ACT_CPU   = 2'b01,
      ACT_LEARN = 2'b10,
      ACT_DROP  = 2'b11
   } action_type;
endpackage : pacl_pkg

// ==== aggr_mask_mem.sv ====
/*
 sixteen-entry aggregation mask memory, one write port, registered read.
 assumes writes and reads from the same clock domain.
*/
`timescale 1ns/1ps
module aggr_mask_mem (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        we,
   input  wire logic [3:0]  waddr,
   input  wire logic [11:0] wdata,
   input  wire logic [3:0]  raddr_a,
   output logic      [11:0] rdata_a,
   input  wire logic [3:0]  raddr_b,
   output logic      [11:0] rdata_b
);
   logic [11:0] mem_r [0:15];

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_ent
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               mem_r[g] <= pacl_pkg::MASK_RST;
            end else if (we && waddr == 4'(g)) begin
               mem_r[g] <= wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_a <= 12'h000;
         rdata_b <= 12'h000;
      end else begin
         rdata_a <= mem_r[raddr_a];
         rdata_b <= mem_r[raddr_b];
      end
   end
endmodule : aggr_mask_mem

// ==== port_access_lag.sv ====
/*
 frame decision logic: mac-based access control and aggregation member select.
 assumes frame header fields arrive with FRM_VALID for one cycle, the mac table
 lookup result FRM_SMAC_KNOWN is valid with them, and software uses apb.
*/
// Decided for this implementation: the APB slave port and the register offsets.
// Notes on behaviour
// - per-port enable redirects frames to 01-80-C2-00-00-03 to the cpu.
// - redirected authentication frames use the configured cpu queue.
// - with learning on in secure or no-learning mode, only frames from known source addresses reach other ports.
// - secure mode: unknown source goes to cpu as learn frame.
// - no-learning: unknown source dropped, no cpu copy.
// - group-destined frame leaves on exactly one member port.
// - four-bit aggregation code picks the member port.
// - code is a fixed function of flow fields, no reordering.
// - code inputs: macs, ipv4 addresses, l4 ports, flow label, each enabled.
// - a group holds up to twelve member ports.
// - any number of groups, limited by port count.
// - one of sixteen masks, indexed by code, gates the destination set.
// - optional random code replaces the computed one, off by default.
`timescale 1ns/1ps
module port_access_lag (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        FRM_VALID,
   input  wire logic [3:0]  FRM_SRC_PORT,
   input  wire logic [47:0] FRM_DMAC,
   input  wire logic [47:0] FRM_SMAC,
   input  wire logic        FRM_IS_IP4,
   input  wire logic        FRM_IS_IP6,
   input  wire logic        FRM_IS_L4,
   input  wire logic [31:0] FRM_SIP,
   input  wire logic [31:0] FRM_DIP,
   input  wire logic [15:0] FRM_SPORT,
   input  wire logic [15:0] FRM_DPORT,
   input  wire logic [19:0] FRM_FLOW_LABEL,
   input  wire logic        FRM_SMAC_KNOWN,
   input  wire logic [11:0] FRM_DEST_MASK,
   input  wire logic [11:0] FRM_SRC_MASK,
   output logic             DEC_VALID,
   output logic [11:0]      DEC_PORT_MASK,
   output logic             DEC_TO_CPU,
   output logic             DEC_LEARN_FRAME,
   output logic [2:0]       DEC_CPU_QUEUE,
   output logic             DEC_DROP,
   output logic [3:0]       DEC_AGGR_CODE
);
   logic [31:0]      port_cfg_r [0:pacl_pkg::NPORTS-1];
   logic [11:0]      redir_ena_r;
   logic [2:0]       cpu_queue_r;
   logic [31:0]      aggr_cfg_r;
   logic [31:0]      fwd_cnt_r;
   logic [31:0]      cpu_cnt_r;
   logic [31:0]      drop_cnt_r;
   logic [15:0]      lfsr_r;
   logic [1:0]       last_act_r;
   logic             wr_en;
   logic             rd_en;
   logic             mask_we;
   logic [11:0]      mask_rd;
   logic [11:0]      mask_dec;
   logic [3:0]       port_idx;
   logic [31:0]      cfg_sel;

   pacl_pkg::state_type  state_r;
   pacl_pkg::action_type act_r;
   pacl_pkg::action_type act_nxt;
   logic [3:0]           ac_nxt;
   logic [3:0]           ac_r;
   logic [11:0]          dest_r;
   logic [11:0]          src_r;
   logic                 is_auth_r;

   assign wr_en    = PSEL && PENABLE && PWRITE;
   assign rd_en    = PSEL && PENABLE && !PWRITE;
   assign port_idx = PADDR[5:2];
   assign mask_we  = wr_en && PADDR[11:6] == pacl_pkg::OFF_AGGR_MASK[11:6];

   // configuration registers
   genvar p;
   generate
      for (p = 0; p < pacl_pkg::NPORTS; p++) begin : g_port
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               port_cfg_r[p] <= pacl_pkg::PORT_CFG_RST;
            end else if (wr_en && PADDR[11:6] == pacl_pkg::OFF_PORT_CFG[11:6] && port_idx == 4'(p)) begin
               port_cfg_r[p] <= PWDATA;
            end
         end
      end
   endgenerate

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         redir_ena_r <= 12'h000;
         cpu_queue_r <= 3'h0;
         aggr_cfg_r  <= pacl_pkg::AGGR_CFG_RST;
      end else if (wr_en) begin
         unique case (PADDR)
            pacl_pkg::OFF_REDIR_ENA: redir_ena_r <= PWDATA[11:0];
            pacl_pkg::OFF_CPUQ:      cpu_queue_r <= PWDATA[2:0];
            pacl_pkg::OFF_AGGR_CFG:  aggr_cfg_r  <= {25'h0, PWDATA[6:0]};
            default: ;
         endcase
      end
   end

   aggr_mask_mem u_mask (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .we      (mask_we),
      .waddr   (PADDR[5:2]),
      .wdata   (PWDATA[11:0]),
      .raddr_a (PADDR[5:2]),
      .rdata_a (mask_rd),
      .raddr_b (ac_nxt),
      .rdata_b (mask_dec)
   );

   // apb read: three-cycle access, pready one cycle after penable
   assign cfg_sel = (port_idx < 4'(pacl_pkg::NPORTS)) ? port_cfg_r[port_idx] : 32'h0;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && PENABLE && !PREADY;
         PSLVERR <= 1'b0;
         if (rd_en && !PREADY) begin
            if (PADDR[11:6] == pacl_pkg::OFF_PORT_CFG[11:6]) begin
               PRDATA <= cfg_sel;
            end else if (PADDR[11:6] == pacl_pkg::OFF_AGGR_MASK[11:6]) begin
               PRDATA <= {20'h0, mask_rd};
            end else begin
               unique case (PADDR)
                  pacl_pkg::OFF_REDIR_ENA: PRDATA <= {20'h0, redir_ena_r};
                  pacl_pkg::OFF_CPUQ:      PRDATA <= {29'h0, cpu_queue_r};
                  pacl_pkg::OFF_AGGR_CFG:  PRDATA <= aggr_cfg_r;
                  pacl_pkg::OFF_STATUS:    PRDATA <= {28'h0, state_r, last_act_r};
                  pacl_pkg::OFF_FWD_CNT:   PRDATA <= fwd_cnt_r;
                  pacl_pkg::OFF_CPU_CNT:   PRDATA <= cpu_cnt_r;
                  pacl_pkg::OFF_DROP_CNT:  PRDATA <= drop_cnt_r;
                  default: begin
                     PRDATA  <= 32'h0;
                     PSLVERR <= 1'b1;
                  end
               endcase
            end
         end
      end
   end

   // aggregation code: xor fold of enabled flow fields
   function automatic logic [3:0] fold(input logic [63:0] v);
      logic [3:0] f;
      f = 4'h0;
      for (int i = 0; i < 16; i++) begin
         f = f ^ v[i*4 +: 4];
      end
      return f;
   endfunction : fold

   always_comb begin
      logic [3:0] c;
      c = 4'h0;
      if (aggr_cfg_r[pacl_pkg::AG_SMAC]) c = c ^ fold({16'h0, FRM_SMAC});
      if (aggr_cfg_r[pacl_pkg::AG_DMAC]) c = c ^ fold({16'h0, FRM_DMAC});
      if (FRM_IS_IP4 && aggr_cfg_r[pacl_pkg::AG_IP4_SIPDIP]) c = c ^ fold({FRM_SIP, FRM_DIP});
      if (FRM_IS_IP4 && FRM_IS_L4 && aggr_cfg_r[pacl_pkg::AG_IP4_L4]) c = c ^ fold({32'h0, FRM_SPORT, FRM_DPORT});
      if (FRM_IS_IP6 && FRM_IS_L4 && aggr_cfg_r[pacl_pkg::AG_IP6_L4]) c = c ^ fold({32'h0, FRM_SPORT, FRM_DPORT});
      if (FRM_IS_IP6 && aggr_cfg_r[pacl_pkg::AG_IP6_FLOW]) c = c ^ fold({44'h0, FRM_FLOW_LABEL});
      ac_nxt = aggr_cfg_r[pacl_pkg::AG_RND] ? lfsr_r[3:0] : c;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         lfsr_r <= pacl_pkg::LFSR_SEED;
      end else begin
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end

   // access decision
   always_comb begin
      logic [31:0] pc;
      pc = (FRM_SRC_PORT < 4'(pacl_pkg::NPORTS)) ? port_cfg_r[FRM_SRC_PORT] : 32'h0;
      act_nxt = pacl_pkg::ACT_FWD;
      if (FRM_DMAC == pacl_pkg::AUTH_DMAC && redir_ena_r[FRM_SRC_PORT]) begin
         act_nxt = pacl_pkg::ACT_CPU;
      end else if (pc[pacl_pkg::PC_PORT_LEARNING_ENABLE] && !FRM_SMAC_KNOWN && !pc[pacl_pkg::PC_LEARN_AUTO]) begin
         if (pc[pacl_pkg::PC_LEARN_CPU]) begin
            act_nxt = pacl_pkg::ACT_LEARN;
         end else if (pc[pacl_pkg::PC_LEARN_DROP]) begin
            act_nxt = pacl_pkg::ACT_DROP;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_r   <= pacl_pkg::ST_IDLE;
         act_r     <= pacl_pkg::ACT_FWD;
         ac_r      <= 4'h0;
         dest_r    <= 12'h000;
         src_r     <= 12'h000;
         is_auth_r <= 1'b0;
      end else begin
         unique case (state_r)
            pacl_pkg::ST_IDLE: begin
               if (FRM_VALID) begin
                  state_r   <= pacl_pkg::ST_LOOK;
                  act_r     <= act_nxt;
                  ac_r      <= ac_nxt;
                  dest_r    <= FRM_DEST_MASK;
                  src_r     <= FRM_SRC_MASK;
                  is_auth_r <= act_nxt == pacl_pkg::ACT_CPU;
               end
            end
            pacl_pkg::ST_LOOK: state_r <= pacl_pkg::ST_DONE;
            pacl_pkg::ST_DONE: state_r <= pacl_pkg::ST_IDLE;
            default:           state_r <= pacl_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         DEC_VALID       <= 1'b0;
         DEC_PORT_MASK   <= 12'h000;
         DEC_TO_CPU      <= 1'b0;
         DEC_LEARN_FRAME <= 1'b0;
         DEC_CPU_QUEUE   <= 3'h0;
         DEC_DROP        <= 1'b0;
         DEC_AGGR_CODE   <= 4'h0;
         last_act_r      <= 2'b00;
         fwd_cnt_r       <= 32'h0;
         cpu_cnt_r       <= 32'h0;
         drop_cnt_r      <= 32'h0;
      end else begin
         DEC_VALID <= state_r == pacl_pkg::ST_LOOK;
         if (state_r == pacl_pkg::ST_LOOK) begin
            DEC_AGGR_CODE   <= ac_r;
            DEC_TO_CPU      <= act_r == pacl_pkg::ACT_CPU || act_r == pacl_pkg::ACT_LEARN;
            DEC_LEARN_FRAME <= act_r == pacl_pkg::ACT_LEARN;
            DEC_CPU_QUEUE   <= cpu_queue_r;
            DEC_DROP        <= act_r == pacl_pkg::ACT_DROP;
            last_act_r      <= act_r;
            if (act_r == pacl_pkg::ACT_FWD) begin
               DEC_PORT_MASK <= dest_r & src_r & mask_dec;
               fwd_cnt_r     <= fwd_cnt_r + 32'h1;
            end else begin
               DEC_PORT_MASK <= 12'h000;
               if (act_r == pacl_pkg::ACT_DROP) begin
                  drop_cnt_r <= drop_cnt_r + 32'h1;
               end else begin
                  cpu_cnt_r <= cpu_cnt_r + 32'h1;
               end
            end
         end
      end
   end
endmodule : port_access_lag

// ==== pacl_sva.sv ====
/* checker of decision timing and outcome; assumes no register writes while a frame is in flight */
`timescale 1ns/1ps
module pacl_sva (
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        FRM_VALID,
   input wire logic [3:0]  FRM_SRC_PORT,
   input wire logic [47:0] FRM_DMAC,
   input wire logic        FRM_SMAC_KNOWN,
   input wire logic [11:0] FRM_DEST_MASK,
   input wire logic [11:0] FRM_SRC_MASK,
   input wire logic        DEC_VALID,
   input wire logic [11:0] DEC_PORT_MASK,
   input wire logic        DEC_TO_CPU,
   input wire logic        DEC_LEARN_FRAME,
   input wire logic [2:0]  DEC_CPU_QUEUE,
   input wire logic        DEC_DROP,
   input wire logic [3:0]  DEC_AGGR_CODE
);
   logic [1:0]  busy_r;
   logic [11:0] redir_r;
   logic [2:0]  cpuq_r;
   logic [3:0]  pcfg_r [16];
   logic [11:0] mask_r [16];
   logic        take, auth, unk;
   assign take = FRM_VALID && busy_r == 2'h0;
   assign auth = FRM_DMAC == pacl_pkg::AUTH_DMAC && redir_r[FRM_SRC_PORT];
   assign unk  = !auth && !FRM_SMAC_KNOWN && pcfg_r[FRM_SRC_PORT][0] && !pcfg_r[FRM_SRC_PORT][3];
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) busy_r <= 2'h0;
      else if (take) busy_r <= 2'h2;
      else if (busy_r != 2'h0) busy_r <= busy_r - 2'h1;
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         redir_r <= 12'h000;
         cpuq_r  <= 3'h0;
         for (int i = 0; i < 16; i++) begin
            pcfg_r[i] <= 4'h0;
            mask_r[i] <= pacl_pkg::MASK_RST;
         end
      end else if (PSEL && PENABLE && PWRITE && PREADY) begin
         if (PADDR == pacl_pkg::OFF_REDIR_ENA) redir_r <= PWDATA[11:0];
         if (PADDR == pacl_pkg::OFF_CPUQ) cpuq_r <= PWDATA[2:0];
         if (PADDR[11:6] == 6'h01) mask_r[PADDR[5:2]] <= PWDATA[11:0];
         if (PADDR[11:6] == 6'h02) pcfg_r[PADDR[5:2]] <= PWDATA[3:0];
      end
   end
   sequence s_to_cpu;
      DEC_VALID && DEC_TO_CPU && !DEC_DROP && DEC_PORT_MASK == 12'h000;
   endsequence
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   a_dec_latency: assert property (take |-> ##2 DEC_VALID) else $error("late decision");
   a_dec_cause: assert property (DEC_VALID |-> $past(take, 2)) else $error("stray decision");
   a_auth_redirect:
      assert property (take && auth |-> ##2 s_to_cpu ##0 !DEC_LEARN_FRAME) else $error("no redirect");
   a_auth_queue:
      assert property (take && auth |-> ##2 DEC_CPU_QUEUE == cpuq_r) else $error("wrong queue");
   a_unknown_learn:
      assert property (take && unk && pcfg_r[FRM_SRC_PORT][1] |-> ##2 s_to_cpu ##0 DEC_LEARN_FRAME)
      else $error("no learn frame");
   a_unknown_drop:
      assert property (take && unk && pcfg_r[FRM_SRC_PORT][2:1] == 2'h2 |-> ##2 DEC_DROP && !DEC_TO_CPU
         && DEC_PORT_MASK == 12'h000) else $error("unknown source not dropped");
   a_known_fwd:
      assert property (take && !auth && FRM_SMAC_KNOWN |-> ##2 !DEC_TO_CPU && !DEC_DROP) else $error("known held");
   a_fwd_mask:
      assert property (DEC_VALID && !DEC_TO_CPU && !DEC_DROP |-> DEC_PORT_MASK == ($past(FRM_DEST_MASK, 2)
         & $past(FRM_SRC_MASK, 2) & mask_r[DEC_AGGR_CODE])) else $error("bad egress set");
   a_dec_hold:
      assert property (!DEC_VALID |-> $stable(DEC_PORT_MASK) && $stable(DEC_AGGR_CODE)) else $error("no hold");
endmodule : pacl_sva
bind port_access_lag pacl_sva pacl_sva_i (.*);

// ==== pacl_mac_model.sv ====
/* mac table kept by the managing cpu; assumes inserts come from the bench */
`timescale 1ns/1ps
module pacl_mac_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        insert,
   input  wire logic [47:0] insert_addr,
   input  wire logic [47:0] smac,
   output logic             known
);
   logic [47:0] tbl_r [4];
   logic [3:0]  vld_r;
   logic [1:0]  wp_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         vld_r <= 4'h0;
         wp_r  <= 2'h0;
      end else if (insert) begin // authenticated address entered
         tbl_r[wp_r] <= insert_addr;
         vld_r[wp_r] <= 1'h1;
         wp_r        <= wp_r + 2'h1;
      end
   end
   always_comb begin
      known = 1'h0;
      for (int i = 0; i < 4; i++) if (vld_r[i] && tbl_r[i] == smac) known = 1'h1;
   end
endmodule : pacl_mac_model

// ==== testbench.sv ====
/* self-checking bench for port_access_lag; assumes pacl_mac_model answers the source lookup */
`timescale 1ns/1ps
module testbench;
   localparam logic [47:0] DM = 48'h02000000AB12;
   localparam logic [47:0] SM = 48'h0A1234567890;
   logic        CORE_CLK = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic [11:0] PADDR = 12'h000, FRM_DEST_MASK = 12'hFFF, FRM_SRC_MASK = 12'hFFF, DEC_PORT_MASK;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd, FRM_SIP = 32'hC0A80A01, FRM_DIP = 32'h0A000207;
   logic        PREADY, PSLVERR, DEC_VALID, DEC_TO_CPU, DEC_LEARN_FRAME, DEC_DROP, FRM_SMAC_KNOWN, err;
   logic        FRM_VALID = 1'h0, FRM_IS_IP4 = 1'h0, FRM_IS_IP6 = 1'h0, FRM_IS_L4 = 1'h1, ins = 1'h0;
   logic [3:0]  FRM_SRC_PORT = 4'h0, DEC_AGGR_CODE;
   logic [47:0] FRM_DMAC = 48'h0, FRM_SMAC = 48'h0, ins_addr = 48'h0;
   logic [15:0] FRM_SPORT = 16'h1F90, FRM_DPORT = 16'hC351;
   logic [19:0] FRM_FLOW_LABEL = 20'h5A3C1;
   logic [2:0]  DEC_CPU_QUEUE;
   int          miscompares = 0, samples_checked = 0, cycles = 0;
   port_access_lag port_access_lag_i (.*);
   pacl_mac_model pacl_mac_model_i (.clk(CORE_CLK), .rst_n(RST_N), .insert(ins), .insert_addr(ins_addr),
                                    .smac(FRM_SMAC), .known(FRM_SMAC_KNOWN));
   initial forever #20 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   function automatic logic [3:0] nib(input logic [63:0] v);
      logic [3:0] x = 4'h0;
      for (int i = 0; i < 16; i++) x ^= v[4*i +: 4];
      return x;
   endfunction : nib
   function automatic logic [11:0] mbr(input logic [3:0] c);
      return 12'h001 << (c[1] ? {1'h0, c[1:0]} + 3'h2 : {1'h0, c[1:0]});
   endfunction : mbr
   task automatic rst();
      @(posedge CORE_CLK);
      RST_N <= 1'h0;
      repeat (12) @(posedge CORE_CLK);
      RST_N <= 1'h1;
   endtask : rst
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge CORE_CLK);
      PSEL   <= 1'h1;
      PWRITE <= w;
      PADDR  <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'h1;
      do @(posedge CORE_CLK); while (PREADY !== 1'h1 && ++n < 16);
      rd  = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'h0;
      PENABLE <= 1'h0;
      check("apb_ready", PREADY, 1'h1);
   endtask : apb
   task automatic frame(input logic [3:0] port, input logic [47:0] dmac, input logic [47:0] smac);
      int n = 0;
      @(posedge CORE_CLK);
      FRM_SRC_PORT <= port;
      FRM_DMAC     <= dmac;
      FRM_SMAC     <= smac;
      FRM_VALID    <= 1'h1;
      @(posedge CORE_CLK);
      FRM_VALID <= 1'h0;
      do @(posedge CORE_CLK); while (DEC_VALID !== 1'h1 && ++n < 8);
      check("dec_valid", DEC_VALID, 1'h1);
   endtask : frame
   task automatic t_auth();
      apb(1'h1, pacl_pkg::OFF_REDIR_ENA, 32'h4);
      apb(1'h1, pacl_pkg::OFF_CPUQ, 32'h5);
      frame(4'h2, pacl_pkg::AUTH_DMAC, SM);
      check("auth_cpu", DEC_TO_CPU, 1'h1);
      check("auth_mask", DEC_PORT_MASK, 12'h000);
      check("auth_queue", DEC_CPU_QUEUE, 3'h5);
      frame(4'h3, pacl_pkg::AUTH_DMAC, SM);
      check("auth_off_port", DEC_TO_CPU, 1'h0);
   endtask : t_auth
   task automatic t_regs();
      apb(1'h0, pacl_pkg::OFF_AGGR_CFG, 32'h0);
      check("aggr_cfg_rst", rd, pacl_pkg::AGGR_CFG_RST);
      apb(1'h0, 12'h0AC, 32'h0);
      check("port_cfg_rst", rd, pacl_pkg::PORT_CFG_RST);
      apb(1'h0, 12'h07C, 32'h0);
      check("mask_rst", rd, {20'h0, pacl_pkg::MASK_RST});
      apb(1'h0, 12'h020, 32'h0);
      check("unmapped_err", err, 1'h1);
      check("unmapped_data", rd, 32'h0);
      apb(1'h1, pacl_pkg::OFF_CPUQ, 32'h3);
      apb(1'h0, pacl_pkg::OFF_CPUQ, 32'h0);
      check("cpuq_rw", rd, 32'h3);
   endtask : t_regs
   task automatic t_secure();
      apb(1'h1, 12'h084, 32'h7);
      frame(4'h1, DM, SM);
      check("learn_cpu", DEC_TO_CPU, 1'h1);
      check("learn_flag", DEC_LEARN_FRAME, 1'h1);
      check("learn_mask", DEC_PORT_MASK, 12'h000);
      @(posedge CORE_CLK);
      ins      <= 1'h1;
      ins_addr <= SM;
      @(posedge CORE_CLK);
      ins <= 1'h0;
      frame(4'h1, DM, SM);
      check("known_fwd", DEC_PORT_MASK, 12'hFFF);
   endtask : t_secure
   task automatic t_nolearn();
      apb(1'h1, 12'h090, 32'h5);
      apb(1'h1, pacl_pkg::OFF_REDIR_ENA, 32'h10);
      frame(4'h4, DM, 48'h0C0000000001);
      check("nl_drop", DEC_DROP, 1'h1);
      check("nl_cpu", DEC_TO_CPU, 1'h0);
      frame(4'h4, pacl_pkg::AUTH_DMAC, 48'h0C0000000001);
      check("nl_auth", DEC_TO_CPU, 1'h1);
      check("nl_queue", DEC_CPU_QUEUE, 3'h3);
      frame(4'h4, DM, SM);
      check("nl_known", DEC_PORT_MASK, 12'hFFF);
      apb(1'h0, pacl_pkg::OFF_DROP_CNT, 32'h0);
      check("drop_count", rd, 32'h1);
   endtask : t_nolearn
   task automatic t_lag();
      logic [3:0] c;
      for (int i = 0; i < 16; i++) apb(1'h1, 12'h040 + 12'(4 * i), {20'h0, 12'hFCC | mbr(4'(i))});
      FRM_DEST_MASK <= 12'h033;
      for (int b = 0; b < 6; b++) begin
         apb(1'h1, pacl_pkg::OFF_AGGR_CFG, 32'h1 << b);
         FRM_IS_IP6 <= b == 0 || b == 3;
         FRM_IS_IP4 <= !(b == 0 || b == 3);
         frame(4'h8, DM, SM);
         c = b == 0 ? nib(64'(FRM_FLOW_LABEL)) : b == 1 ? nib({FRM_SIP, FRM_DIP})
           : b < 4 ? nib(64'({FRM_SPORT, FRM_DPORT})) : b == 4 ? nib(64'(DM)) : nib(64'(SM));
         check("aggr_code", DEC_AGGR_CODE, c);
         check("aggr_member", DEC_PORT_MASK, mbr(c));
      end
      apb(1'h1, pacl_pkg::OFF_AGGR_CFG, 32'h3F);
      FRM_IS_IP6 <= 1'h0;
      FRM_IS_IP4 <= 1'h1;
      c = nib({FRM_SIP, FRM_DIP}) ^ nib(64'({FRM_SPORT, FRM_DPORT})) ^ nib(64'(DM)) ^ nib(64'(SM));
      repeat (2) begin
         frame(4'h8, DM, SM);
         check("flow_code", DEC_AGGR_CODE, c);
      end
      apb(1'h1, pacl_pkg::OFF_AGGR_CFG, 32'h7F);
      frame(4'h8, DM, SM);
      check("rnd_one_port", 32'($countones(DEC_PORT_MASK)), 32'h1);
   endtask : t_lag
   initial begin
      rst();
      t_auth();
      rst();
      t_regs();
      t_secure();
      t_nolearn();
      t_lag();
      summarize();
   end
endmodule : testbench
